// File: alcc_defs.vh
// constants for the ambient light comparator control block
`ifndef ALCC_DEFS_VH
`define ALCC_DEFS_VH
// register offsets
`define ALCC_ADDR_CFG_STAT 8'h30
`define ALCC_ADDR_SENS1 8'h31
`define ALCC_ADDR_SENS2 8'h32
`define ALCC_ADDR_S1_TRIP 8'h33
// light_cmp_config_status fields
`define ALCC_BIT_S2_DARK 7
`define ALCC_BIT_S2_OFFICE 6
`define ALCC_BIT_S1_DARK 5
`define ALCC_BIT_S1_OFFICE 4
`define ALCC_BIT_S2_IEN 3
`define ALCC_BIT_S1_IEN 2
`define ALCC_BIT_S2_EN 1
`define ALCC_BIT_S1_EN 0
`define ALCC_CTRL_W 4
`define ALCC_CTRL_LSB 0
// sensor config fields
`define ALCC_CONSECUTIVE_COUNT_SELECT_MSB 5
`define ALCC_CONSECUTIVE_COUNT_SELECT_LSB 3
`define ALCC_BIT_FORCE 2
`define ALCC_BIT_DARK_EN 1
`define ALCC_BIT_OFFICE_EN 0
`define ALCC_SCFG_W 6
// levels
`define ALCC_LVL_OUTDOOR 2'h0
`define ALCC_LVL_OFFICE 2'h1
`define ALCC_LVL_DARK 2'h2
// filter counter
`define ALCC_CNT_W 8
`define ALCC_CNT_ONE 8'h01
`define ALCC_CNT_ZERO 8'h00
// measurement period
`define ALCC_MEAS_TIME_US 80000
`define ALCC_CLK_MHZ 10
`define ALCC_TICK_W 20
`define ALCC_TICK_ZERO 20'h00000
`define ALCC_TICK_ONE 20'h00001
`endif

// File: alcc_ctrl.v
// ambient light comparator control and status logic, two sensors
//
// Behaviour
// - Status bit 7 shows sensor 2 has gone to dark level and is 0 while light is above dark.
// - Status bit 6 shows sensor 2 has gone to office level and is 0 while light is above office.
// - Status bit 5 shows sensor 1 has gone to dark level and is 0 while light is above dark.
// - Status bit 4 shows sensor 1 has gone to office level and is 0 while light is above office.
// - Status register bit 3 enables the sensor 2 interrupt when 1 and disables it when 0.
// - Status register bit 2 enables the sensor 1 interrupt when 1 and disables it when 0.
// - Status register bit 1 enables the sensor 2 input when 1 and disables it when 0.
// - Status register bit 0 enables the sensor 1 input when 1 and disables it when 0.
// - Bits 5:3 of a sensor config select 2^code agreeing measurements of about 0.08 s each.
// - Writing 1 to bit 2 of a sensor config forces a conversion and hardware clears the bit on the same edge as the status update.
// - Bit 1 of sensor 1 config turns its dark comparator on when 1 and off when 0.
// - Bit 1 of sensor 2 config turns its dark comparator on when 1 and off when 0.
// - Bit 0 of each sensor config turns that sensor's office comparator on when 1 and off when 0.
// - When both comparators of a sensor report, the dark decision wins over the office decision.
// - Sensor 1 reading below its 8-bit office trip value moves it to office level and sets its office bit.
`timescale 1ns/100ps
`include "alcc_defs.vh"

module alcc_ctrl #(
  parameter MEAS_CYCLES = `ALCC_MEAS_TIME_US * `ALCC_CLK_MHZ
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] sensor1_level_i,
  input wire sensor2_office_below_i,
  input wire [1:0] dark_below_i,
  output reg [7:0] reg_rdata_o,
  output reg [1:0] input_enable_o,
  output reg [1:0] dark_comparator_enable_o,
  output reg [1:0] office_comparator_enable_o,
  output reg irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // control registers and measurement tick

  localparam [`ALCC_TICK_W-1:0] MEAS_LAST = MEAS_CYCLES - 1;

  reg [`ALCC_CTRL_W-1:0] ctrl;
  reg [7:0] office_trip;
  reg [`ALCC_TICK_W-1:0] tick_cnt;
  reg meas_tick;
  wire [2*`ALCC_SCFG_W-1:0] scfg_w;
  wire [3:0] flags_w;
  wire [1:0] event_w;
  wire [1:0] office_below;

  // sensor 1 office compare is done here against its trip value
  assign office_below[0] = sensor1_level_i < office_trip;
  assign office_below[1] = sensor2_office_below_i;

  wire wr_ctrl = reg_wr_i && (reg_addr_i == `ALCC_ADDR_CFG_STAT);

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl <= {`ALCC_CTRL_W{1'b0}};
      office_trip <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        // status bits are read-only, only the low nibble is stored
        ctrl <= reg_wdata_i[`ALCC_CTRL_W-1:0];
      end
      if (reg_wr_i && (reg_addr_i == `ALCC_ADDR_S1_TRIP)) begin
        office_trip <= reg_wdata_i;
      end
    end
  end

  // free running period of one measurement
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      tick_cnt <= `ALCC_TICK_ZERO;
      meas_tick <= 1'b0;
    end else if (tick_cnt == MEAS_LAST) begin
      tick_cnt <= `ALCC_TICK_ZERO;
      meas_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + `ALCC_TICK_ONE;
      meas_tick <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per sensor filter and level tracking

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sens
      reg [`ALCC_SCFG_W-1:0] cfg;
      reg [1:0] level;
      reg [1:0] cand;
      reg [`ALCC_CNT_W-1:0] cnt;
      reg [1:0] raw;
      reg [1:0] next_level;
      reg [1:0] next_cand;
      reg [`ALCC_CNT_W-1:0] next_cnt;
      wire [7:0] sel_addr = gi ? `ALCC_ADDR_SENS2 : `ALCC_ADDR_SENS1;
      wire wr_cfg = reg_wr_i && (reg_addr_i == sel_addr);
      wire [2:0] consecutive_count_select = cfg[`ALCC_CONSECUTIVE_COUNT_SELECT_MSB:`ALCC_CONSECUTIVE_COUNT_SELECT_LSB];
      wire [`ALCC_CNT_W-1:0] need = `ALCC_CNT_ONE << consecutive_count_select;
      wire in_en = ctrl[`ALCC_BIT_S1_EN + gi];
      wire force_req = cfg[`ALCC_BIT_FORCE];
      wire sample = in_en && (meas_tick || force_req);

      always @* begin
        // dark checked first so it overrides office
        if (cfg[`ALCC_BIT_DARK_EN] && dark_below_i[gi]) begin
          raw = `ALCC_LVL_DARK;
        end else if (cfg[`ALCC_BIT_OFFICE_EN] && office_below[gi]) begin
          raw = `ALCC_LVL_OFFICE;
        end else begin
          raw = `ALCC_LVL_OUTDOOR;
        end
        next_level = level;
        next_cand = cand;
        next_cnt = cnt;
        if (!in_en) begin
          // a disabled input reports no level at all
          next_level = `ALCC_LVL_OUTDOOR;
          next_cnt = `ALCC_CNT_ZERO;
        end else if (sample) begin
          if (raw == level) begin
            next_cnt = `ALCC_CNT_ZERO;
          end else if ((raw == cand) && (cnt != `ALCC_CNT_ZERO)) begin
            next_cnt = cnt + `ALCC_CNT_ONE;
          end else begin
            next_cand = raw;
            next_cnt = `ALCC_CNT_ONE;
          end
          // level only moves once enough agreeing samples are seen
          if ((raw != level) && (next_cnt >= need)) begin
            next_level = raw;
            next_cnt = `ALCC_CNT_ZERO;
          end
        end
      end

      always @(posedge sys_clk_i) begin
        if (srst_i) begin
          cfg <= {`ALCC_SCFG_W{1'b0}};
          level <= `ALCC_LVL_OUTDOOR;
          cand <= `ALCC_LVL_OUTDOOR;
          cnt <= `ALCC_CNT_ZERO;
        end else begin
          level <= next_level;
          cand <= next_cand;
          cnt <= next_cnt;
          if (wr_cfg) begin
            // a write landing on the clear edge keeps the new request
            cfg <= reg_wdata_i[`ALCC_SCFG_W-1:0];
          end else if (force_req) begin
            // status is updated on this same edge, so clear is safe
            cfg[`ALCC_BIT_FORCE] <= 1'b0;
          end
        end
      end

      assign scfg_w[gi*`ALCC_SCFG_W +: `ALCC_SCFG_W] = cfg;
      assign flags_w[gi*2] = (level == `ALCC_LVL_OFFICE);
      assign flags_w[gi*2+1] = (level == `ALCC_LVL_DARK);
      assign event_w[gi] = ctrl[`ALCC_BIT_S1_IEN + gi] && (
        ((next_level == `ALCC_LVL_OFFICE) && (level != `ALCC_LVL_OFFICE)) ||
        ((next_level == `ALCC_LVL_DARK) && (level != `ALCC_LVL_DARK)));
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // read port and outputs

  wire [7:0] stat_w = {flags_w[3], flags_w[2], flags_w[1], flags_w[0], ctrl};

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
      input_enable_o <= 2'h0;
      dark_comparator_enable_o <= 2'h0;
      office_comparator_enable_o <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      if (reg_rd_i) begin
        case (reg_addr_i)
          // status flags follow the filtered level
          `ALCC_ADDR_CFG_STAT: reg_rdata_o <= stat_w;
          `ALCC_ADDR_SENS1: reg_rdata_o <= {2'h0, scfg_w[`ALCC_SCFG_W-1:0]};
          `ALCC_ADDR_SENS2:
            reg_rdata_o <= {2'h0, scfg_w[2*`ALCC_SCFG_W-1:`ALCC_SCFG_W]};
          `ALCC_ADDR_S1_TRIP: reg_rdata_o <= office_trip;
          default: reg_rdata_o <= 8'h00;
        endcase
      end
      input_enable_o <= ctrl[`ALCC_BIT_S2_EN:`ALCC_BIT_S1_EN];
      dark_comparator_enable_o <= {scfg_w[`ALCC_SCFG_W + `ALCC_BIT_DARK_EN],
                                   scfg_w[`ALCC_BIT_DARK_EN]};
      office_comparator_enable_o <=
        {scfg_w[`ALCC_SCFG_W + `ALCC_BIT_OFFICE_EN],
         scfg_w[`ALCC_BIT_OFFICE_EN]};
      // one-cycle pulse; the shared interrupt latch sits outside
      irq_o <= |event_w;
    end
  end

endmodule // alcc_ctrl

// File: alcc_light_model.sv
// light sensor front end model feeding the comparator block
`timescale 1ns/100ps
module alcc_light_model (
  input logic clk_i,
  input logic [9:0] ua_i,
  input logic s2_office_i,
  input logic [1:0] dark_i,
  output logic [7:0] level_o = 8'hFF,
  output logic s2_below_o = 1'b0,
  output logic [1:0] dark_o = 2'h0
);
  // analog side settles one clock late; readings saturate at full scale
  always @(posedge clk_i) begin
    level_o <= (ua_i > 10'h3FC) ? 8'hFF : ua_i[9:2];
    s2_below_o <= s2_office_i;
    dark_o <= dark_i;
  end
endmodule // alcc_light_model

// File: alcc_ctrl_chk.sv
// port assertions for the light comparator control block
`timescale 1ns/100ps
module alcc_ctrl_chk #(parameter MEAS_CYCLES = 20) (
  input logic sys_clk_i,
  input logic srst_i,
  input logic [7:0] reg_addr_i,
  input logic [7:0] reg_wdata_i,
  input logic reg_wr_i,
  input logic reg_rd_i,
  input logic [7:0] reg_rdata_o,
  input logic [1:0] input_enable_o,
  input logic [1:0] dark_comparator_enable_o,
  input logic [1:0] office_comparator_enable_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_wr(logic [7:0] a); reg_wr_i && reg_addr_i == a; endsequence
  sequence s_rd(logic [7:0] a); reg_rd_i && reg_addr_i == a; endsequence
  ctl_rb_a: assert property (s_wr(8'h30) ##2 s_rd(8'h30)
    |=> reg_rdata_o[3:0] == $past(reg_wdata_i[3:0], 3)) else $error("ctl");
  trip_rb_a: assert property (s_wr(8'h33) ##2 s_rd(8'h33)
    |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("trip");
  in_en_a: assert property (s_wr(8'h30)
    |=> ##1 input_enable_o == $past(reg_wdata_i[1:0], 2)) else $error("en");
  dark1_en_a: assert property (s_wr(8'h31) |=> ##1
    dark_comparator_enable_o[0] == $past(reg_wdata_i[1], 2)) else $error("d1");
  dark2_en_a: assert property (s_wr(8'h32) |=> ##1
    dark_comparator_enable_o[1] == $past(reg_wdata_i[1], 2)) else $error("d2");
  office_en_a: assert property (s_wr(8'h31) |=> ##1
    office_comparator_enable_o[0] == $past(reg_wdata_i[0], 2)) else $error("o");
  unmapped_a: assert property (reg_rd_i && reg_addr_i > 8'h33
    |=> reg_rdata_o == 8'h00) else $error("unmapped read");
  rd_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
endmodule // alcc_ctrl_chk
bind alcc_ctrl alcc_ctrl_chk #(.MEAS_CYCLES(MEAS_CYCLES)) i_chk (.sys_clk_i,
  .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .input_enable_o, .dark_comparator_enable_o, .office_comparator_enable_o);

// File: alcc_ctrl_bench.sv
// self-checking bench for the light comparator control block
`timescale 1ns/100ps
module alcc_ctrl_bench;
  logic sys_clk_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, rd_d = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, r;
  logic [7:0] sensor1_level_i, exp_q[$];
  logic [1:0] dk = 2'h0, dark_below_i, input_enable_o;
  logic [1:0] dark_comparator_enable_o, office_comparator_enable_o;
  logic [9:0] ua = 10'h3FC;
  logic s2 = 0, sensor2_office_below_i, irq_o;
  int n_fail = 0, cmp_count = 0, n_irq = 0, cyc = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  alcc_light_model i_model (.clk_i(sys_clk_i), .ua_i(ua), .s2_office_i(s2),
    .dark_i(dk), .level_o(sensor1_level_i),
    .s2_below_o(sensor2_office_below_i), .dark_o(dark_below_i));
  // a short measurement period of 20 cycles keeps filter runs under a hundred cycles
  alcc_ctrl #(.MEAS_CYCLES(20)) i_dut (.sys_clk_i, .srst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .sensor1_level_i,
    .sensor2_office_below_i, .dark_below_i, .reg_rdata_o, .input_enable_o,
    .dark_comparator_enable_o, .office_comparator_enable_o, .irq_o);
  task chk(input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge sys_clk_i) #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(posedge sys_clk_i) #1;
    reg_wr_i = 0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge sys_clk_i) #1;
    reg_addr_i = a;
    reg_rd_i = 1;
    exp_q.push_back(e);
    @(posedge sys_clk_i) #1;
    reg_rd_i = 0;
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk_i) rd_d <= reg_rd_i;
  always @(negedge sys_clk_i) begin
    if (rd_d) chk(exp_q.pop_front(), reg_rdata_o);
    if (irq_o === 1'b1) n_irq++;
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(60));
    repeat (8) @(posedge sys_clk_i);
    #1 srst_i = 0;
    wr(8'h40, 8'hFF);
    for (int a = 8'h30; a < 8'h35; a++) rd(8'(a), 8'h00);
    r = 8'($urandom);
    wr(8'h33, r);
    rd(8'h33, r);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h0F);
    wr(8'h31, 8'hC7);
    repeat (2) @(posedge sys_clk_i);
    rd(8'h31, 8'h03);
    $display("test registers done");
    wr(8'h33, 8'h80);
    wr(8'h31, 8'h11);
    ua = 10'($urandom % 512);
    repeat (55) @(posedge sys_clk_i);
    rd(8'h30, 8'h0F);
    repeat (35) @(posedge sys_clk_i);
    rd(8'h30, 8'h1F);
    $display("test filter done");
    wr(8'h32, 8'h03);
    s2 = 1;
    dk = 2'h2;
    repeat (25) @(posedge sys_clk_i);
    rd(8'h30, 8'h9F);
    wr(8'h30, 8'h05);
    repeat (3) @(posedge sys_clk_i);
    rd(8'h30, 8'h15);
    dk = 2'h3;
    wr(8'h31, 8'h03);
    repeat (25) @(posedge sys_clk_i);
    rd(8'h30, 8'h25);
    dk = 2'h1;
    wr(8'h30, 8'h07);
    repeat (25) @(posedge sys_clk_i);
    rd(8'h30, 8'h67);
    repeat (3) @(posedge sys_clk_i);
    chk(8'h03, n_irq[7:0]);
    $display("test levels done");
    end_of_test();
  end
endmodule // alcc_ctrl_bench
